// ==== design/mmcs_top.v ====
// MAC and PHY management control, enables, filter and statistics
// Summary of operation
// - MAC enable sets both enables, resets PHYSICAL_SIGNALING_LAYER
// - MAC disable clears enables, aborts activity
// - Transmit enable set allows frame sending
// - Transmit enable clear stops new frames
// - Multicast enable restores multicast reception, readable
// - Multicast disable blocks further multicast frames
// - Station address readable and writable
// - Thirty-two collision histogram counters kept
// - Success after n attempts bumps element n-1
// - Initialize runs MAC init and PHYSICAL_SIGNALING_LAYER init
// - Add action inserts group address
// - Delete action removes group address
// - Self-test reports result, loops back MII only when MII present
// - PHY kind equals defining clause number
// - Symbol error counted once per carrier
// - No symbol error count with collision
// - Heartbeat errors counted, never at 100M
// - Disabled PHY isolated only when MII present; reception refused only with all PHYs disabled
// - Admin state survives station reset when a valid retained copy is given
// - Enabling one PHY disables all others
// - MII absent clears all isolation, MII present restores it
`include "mmcs_map.vh"
module mmcs_top #(
  parameter NUM_PHY       = 2,
  parameter FILTER_DEPTH  = 16,
  parameter CNT_W         = 32,
  parameter ADMIN_DEFAULT = 1
) (
  input  wire                   I_CLK_SYS,
  input  wire                   I_NRST,
  input  wire                   I_MAC_ENABLE_WR,
  input  wire                   I_MAC_ENABLE_VAL,
  input  wire                   I_TX_ENABLE_WR,
  input  wire                   I_TX_ENABLE_VAL,
  input  wire                   I_MCAST_RX_ENABLE_WR,
  input  wire                   I_MCAST_RX_ENABLE_VAL,
  input  wire                   I_STATION_ADDR_WR,
  input  wire [47:0]            I_STATION_ADDR,
  input  wire                   I_MAC_INIT,
  input  wire                   I_GROUP_ADD,
  input  wire                   I_GROUP_DEL,
  input  wire [47:0]            I_GROUP_ADDR,
  input  wire                   I_SELF_TEST,
  input  wire                   I_MII_PRESENT,
  input  wire                   I_LOOPBACK_OK,
  input  wire                   I_SELF_TEST_FAIL,
  input  wire                   I_TX_DONE,
  input  wire                   I_TX_OK,
  input  wire [5:0]             I_TX_ATTEMPTS,
  input  wire [47:0]            I_RX_DEST_ADDR,
  input  wire                   I_CARRIER,
  input  wire                   I_SYMBOL_ERROR,
  input  wire                   I_COLLISION,
  input  wire                   I_HEARTBEAT_ERR,
  input  wire                   I_PHY_IS_100M,
  input  wire [7:0]             I_PHY_KIND,
  input  wire                   I_ADMIN_WR,
  input  wire [NUM_PHY-1:0]     I_ADMIN_SEL,
  input  wire                   I_ADMIN_ENABLE,
  input  wire [NUM_PHY-1:0]     I_ADMIN_NV,
  input  wire                   I_ADMIN_NV_VALID,
  input  wire [4:0]             I_HIST_INDEX,
  output reg                    O_RX_ENABLE,
  output reg                    O_TX_ENABLE,
  output reg                    O_MCAST_RX_ENABLE,
  output reg  [47:0]            O_STATION_ADDR,
  output reg                    O_ADDR_ACCEPT,
  output reg                    O_ABORT,
  output reg                    O_PLS_RESET,
  output reg                    O_MAC_BUSY,
  output reg                    O_MII_LOOPBACK,
  output reg                    O_SELF_TEST_DONE,
  output reg                    O_SELF_TEST_PASS,
  output reg                    O_FILTER_FULL,
  output reg  [7:0]             O_PHY_KIND,
  output reg  [NUM_PHY-1:0]     O_PHY_ADMIN,
  output reg  [NUM_PHY-1:0]     O_PHY_ISOLATE,
  output wire [CNT_W-1:0]       O_HIST_COUNT,
  output wire [CNT_W-1:0]       O_SYMBOL_ERR_COUNT,
  output wire [CNT_W-1:0]       O_HEARTBEAT_ERR_COUNT
);
  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam INIT_CYC_I = (`MMCS_INIT_NS * `MMCS_CLK_MHZ + 999) / 1000;
  localparam ST_CYC_I   = (`MMCS_SELFTEST_NS * `MMCS_CLK_MHZ + 999) / 1000;
  localparam [11:0] INIT_CYC = INIT_CYC_I[11:0];
  localparam [11:0] ST_CYC   = ST_CYC_I[11:0];
  localparam [11:0] ONE12    = 12'h001;

  // One-hot states of the action sequencer
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_INIT = 4'h2;
  localparam [3:0] S_TEST = 4'h4;
  localparam [3:0] S_LOOP = 4'h8;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [11:0] timer_r;
  reg  [11:0] timer_nxt;
  reg         fail_r;
  reg         fail_nxt;
  reg         admin_loaded_r;
  wire        filter_match;
  wire        filter_full;
  wire        is_group;
  wire        init_go;

  assign init_go  = I_MAC_INIT && state_r == S_IDLE;
  assign is_group = I_RX_DEST_ADDR[`MMCS_GROUP_BIT];

  // ----------------------------------------
  // Enables and station address
  // ----------------------------------------
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RX_ENABLE       <= 1'b0;
      O_TX_ENABLE       <= 1'b0;
      O_MCAST_RX_ENABLE <= 1'b1;
      O_STATION_ADDR    <= `MMCS_NULL_ADDR;
      O_ABORT           <= 1'b0;
      O_PLS_RESET       <= 1'b0;
    end else begin
      O_ABORT     <= 1'b0;
      O_PLS_RESET <= 1'b0;
      if (I_MAC_ENABLE_WR && I_MAC_ENABLE_VAL) begin
        O_RX_ENABLE <= 1'b1;
        O_TX_ENABLE <= 1'b1;
        O_PLS_RESET <= 1'b1;
      end else if (I_MAC_ENABLE_WR) begin
        O_RX_ENABLE <= 1'b0;
        O_TX_ENABLE <= 1'b0;
        O_ABORT     <= 1'b1;
      end else if (I_TX_ENABLE_WR) begin
        O_TX_ENABLE <= I_TX_ENABLE_VAL;
      end
      if (state_r == S_INIT && timer_r == ONE12) begin
        O_PLS_RESET <= 1'b1;
      end
      if (I_MCAST_RX_ENABLE_WR) begin
        O_MCAST_RX_ENABLE <= I_MCAST_RX_ENABLE_VAL;
      end
      // Writes of group or null addresses are the caller's fault
      if (I_STATION_ADDR_WR) begin
        O_STATION_ADDR <= I_STATION_ADDR;
      end
    end
  end

  // ----------------------------------------
  // Address recognition
  // ----------------------------------------
  mmcs_group_filter #(
    .ENTRIES (FILTER_DEPTH)
  ) u_filter (
    .i_clk        (I_CLK_SYS),
    .i_nrst       (I_NRST),
    .i_init       (init_go),
    .i_add        (I_GROUP_ADD),
    .i_del        (I_GROUP_DEL),
    .i_addr       (I_GROUP_ADDR),
    .i_match_addr (I_RX_DEST_ADDR),
    .o_match      (filter_match),
    .o_full       (filter_full)
  );

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ADDR_ACCEPT <= 1'b0;
      O_FILTER_FULL <= 1'b0;
    end else begin
      O_FILTER_FULL <= filter_full;
      O_ADDR_ACCEPT <= O_RX_ENABLE && (|O_PHY_ADMIN) &&
                       ((!is_group && I_RX_DEST_ADDR == O_STATION_ADDR) ||
                        (is_group && O_MCAST_RX_ENABLE &&
                         (&I_RX_DEST_ADDR || filter_match)));
    end
  end

  // ----------------------------------------
  // Initialize and self-test sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    fail_nxt  = fail_r;
    case (state_r)
      S_IDLE: begin
        if (I_MAC_INIT) begin
          state_nxt = S_INIT;
          timer_nxt = INIT_CYC;
        end else if (I_SELF_TEST) begin
          state_nxt = S_TEST;
          timer_nxt = ST_CYC;
          fail_nxt  = 1'b0;
        end
      end
      S_INIT: begin
        timer_nxt = timer_r - ONE12;
        if (timer_r == ONE12) begin
          state_nxt = S_IDLE;
        end
      end
      S_TEST: begin
        timer_nxt = timer_r - ONE12;
        fail_nxt  = fail_r | I_SELF_TEST_FAIL;
        if (timer_r == ONE12) begin
          state_nxt = I_MII_PRESENT ? S_LOOP : S_IDLE;
          timer_nxt = ST_CYC;
        end
      end
      S_LOOP: begin
        timer_nxt = timer_r - ONE12;
        if (I_LOOPBACK_OK || timer_r == ONE12) begin
          state_nxt = S_IDLE;
          fail_nxt  = fail_r | !I_LOOPBACK_OK;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        timer_nxt = 12'h000;
      end
    endcase
  end

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      state_r          <= S_IDLE;
      timer_r          <= 12'h000;
      fail_r           <= 1'b0;
      O_MAC_BUSY       <= 1'b0;
      O_MII_LOOPBACK   <= 1'b0;
      O_SELF_TEST_DONE <= 1'b0;
      O_SELF_TEST_PASS <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      timer_r          <= timer_nxt;
      fail_r           <= fail_nxt;
      O_MAC_BUSY       <= state_nxt != S_IDLE;
      O_MII_LOOPBACK   <= state_nxt == S_LOOP;
      O_SELF_TEST_DONE <= state_r != S_IDLE && state_r != S_INIT && state_nxt == S_IDLE;
      if (state_r != S_IDLE && state_r != S_INIT && state_nxt == S_IDLE) begin
        O_SELF_TEST_PASS <= !fail_nxt;
      end
    end
  end

  // ----------------------------------------
  // PHY kind and administrative state
  // ----------------------------------------
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PHY_KIND <= `MMCS_PHY_KIND_UNKNOWN;
    end else begin
      case (I_PHY_KIND)
        `MMCS_PHY_KIND_MANCH,
        `MMCS_PHY_KIND_8B6T,
        `MMCS_PHY_KIND_4B5B,
        `MMCS_PHY_KIND_NONE,
        `MMCS_PHY_KIND_UNKNOWN: O_PHY_KIND <= I_PHY_KIND;
        default:                O_PHY_KIND <= `MMCS_PHY_KIND_OTHER;
      endcase
    end
  end

  // Admin state is restored from the retained copy after reset when I_ADMIN_NV_VALID is set, else loaded from ADMIN_DEFAULT
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PHY_ADMIN    <= {NUM_PHY{1'b0}};
      admin_loaded_r <= 1'b0;
    end else if (!admin_loaded_r) begin
      if (I_ADMIN_NV_VALID) begin
        O_PHY_ADMIN <= I_ADMIN_NV & (~(I_ADMIN_NV - {{(NUM_PHY-1){1'b0}}, 1'b1}));
      end else begin
        O_PHY_ADMIN <= ADMIN_DEFAULT[NUM_PHY-1:0] & {{(NUM_PHY-1){1'b0}}, 1'b1};
      end
      admin_loaded_r <= 1'b1;
    end else if (I_ADMIN_WR && I_ADMIN_ENABLE) begin
      O_PHY_ADMIN <= I_ADMIN_SEL;
    end else if (I_ADMIN_WR) begin
      O_PHY_ADMIN <= O_PHY_ADMIN & ~I_ADMIN_SEL;
    end
  end

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PHY_ISOLATE <= {NUM_PHY{1'b1}};
    end else begin
      O_PHY_ISOLATE <= I_MII_PRESENT ? ~O_PHY_ADMIN : {NUM_PHY{1'b0}};
    end
  end

  // ----------------------------------------
  // Statistics
  // ----------------------------------------
  reg                         carrier_d_r;
  reg                         sym_seen_r;
  reg                         col_seen_r;
  wire                        carrier_end;
  wire                        sym_inc;
  wire                        hb_inc;
  wire [`MMCS_HIST_ENTRIES-1:0] hist_inc;
  wire [CNT_W-1:0]            hist_cnt [0:`MMCS_HIST_ENTRIES-1];

  assign carrier_end = carrier_d_r && !I_CARRIER;
  assign sym_inc = carrier_end && sym_seen_r && !col_seen_r;
  assign hb_inc  = I_HEARTBEAT_ERR && !I_PHY_IS_100M;

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      carrier_d_r <= 1'b0;
      sym_seen_r  <= 1'b0;
      col_seen_r  <= 1'b0;
    end else begin
      carrier_d_r <= I_CARRIER;
      if (I_CARRIER && !carrier_d_r) begin
        sym_seen_r <= I_SYMBOL_ERROR;
        col_seen_r <= I_COLLISION;
      end else if (I_CARRIER) begin
        sym_seen_r <= sym_seen_r | I_SYMBOL_ERROR;
        col_seen_r <= col_seen_r | I_COLLISION;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MMCS_HIST_ENTRIES; g = g + 1) begin : g_hist
      assign hist_inc[g] = I_TX_DONE && I_TX_OK &&
                           ({{26{1'b0}}, I_TX_ATTEMPTS} == g + 1);
      mmcs_event_counter #(
        .WIDTH (CNT_W)
      ) u_hist (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_inc   (hist_inc[g]),
        .o_count (hist_cnt[g])
      );
    end
  endgenerate

  assign O_HIST_COUNT = hist_cnt[I_HIST_INDEX];

  mmcs_event_counter #(
    .WIDTH (CNT_W)
  ) u_sym_cnt (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_inc   (sym_inc),
    .o_count (O_SYMBOL_ERR_COUNT)
  );

  mmcs_event_counter #(
    .WIDTH (CNT_W)
  ) u_hb_cnt (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_inc   (hb_inc),
    .o_count (O_HEARTBEAT_ERR_COUNT)
  );
endmodule

// ==== design/mmcs_map.vh ====
// Constants for the MAC and PHY management control and statistics block
`ifndef MMCS_MAP_VH
`define MMCS_MAP_VH
// ----------------------------------------
// PHY kind codes
// ----------------------------------------
`define MMCS_PHY_KIND_UNKNOWN 8'h00
`define MMCS_PHY_KIND_MANCH   8'h07
`define MMCS_PHY_KIND_8B6T    8'h17
`define MMCS_PHY_KIND_4B5B    8'h18
`define MMCS_PHY_KIND_NONE    8'hfe
`define MMCS_PHY_KIND_OTHER   8'hff
// ----------------------------------------
// Address fields and sizes
// ----------------------------------------
`define MMCS_GROUP_BIT        0
`define MMCS_NULL_ADDR        48'h000000000000
`define MMCS_HIST_ENTRIES     32
`define MMCS_ZERO_CNT         32'h00000000
`define MMCS_ONE_CNT          32'h00000001
// ----------------------------------------
// Timing
// ----------------------------------------
`define MMCS_CLK_MHZ          200
`define MMCS_INIT_NS          100
`define MMCS_SELFTEST_NS      2000
`endif

// ==== design/mmcs_event_counter.v ====
// Wrapping event counter that management cannot clear
module mmcs_event_counter #(
  parameter WIDTH = 32
) (
  input  wire             i_clk,
  input  wire             i_nrst,
  input  wire             i_inc,
  output reg  [WIDTH-1:0] o_count
);
  // Wraps to zero on overflow
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= {WIDTH{1'b0}};
    end else if (i_inc) begin
      o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== design/mmcs_group_filter.v ====
// Multicast group address filter with add and delete actions
module mmcs_group_filter #(
  parameter ENTRIES = 16
) (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_init,
  input  wire        i_add,
  input  wire        i_del,
  input  wire [47:0] i_addr,
  input  wire [47:0] i_match_addr,
  output reg         o_match,
  output reg         o_full
);
  reg  [47:0]        addr_mem [0:ENTRIES-1];
  reg  [ENTRIES-1:0] valid_r;
  reg  [ENTRIES-1:0] hit;
  reg  [ENTRIES-1:0] look;
  reg  [ENTRIES-1:0] free_sel;
  reg                found;
  integer            k;

  always @* begin
    hit      = {ENTRIES{1'b0}};
    look     = {ENTRIES{1'b0}};
    free_sel = {ENTRIES{1'b0}};
    found    = 1'b0;
    for (k = 0; k < ENTRIES; k = k + 1) begin
      hit[k]  = valid_r[k] && (addr_mem[k] == i_addr);
      look[k] = valid_r[k] && (addr_mem[k] == i_match_addr);
      if (!valid_r[k] && !found) begin
        free_sel[k] = 1'b1;
        found       = 1'b1;
      end
    end
    // Same-cycle match keeps it aligned with the address it belongs to
    o_match  = |look;
  end

  always @(posedge i_clk) begin
    for (k = 0; k < ENTRIES; k = k + 1) begin
      if (i_add && !(|hit) && free_sel[k]) begin
        addr_mem[k] <= i_addr;
      end
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_r <= {ENTRIES{1'b0}};
      o_full  <= 1'b0;
    end else begin
      if (i_init) begin
        valid_r <= {ENTRIES{1'b0}};
      end else if (i_del) begin
        valid_r <= valid_r & ~hit;
      end else if (i_add && !(|hit)) begin
        valid_r <= valid_r | free_sel;
      end
      o_full  <= &valid_r;
    end
  end
endmodule

// ==== testbench/mmcs_top_assertions.sv ====
// Port-level assertions for the management control and statistics block
module mmcs_top_assertions #(
  parameter NUM_PHY = 2,
  parameter CNT_W   = 32
) (
  input logic               I_CLK_SYS,
  input logic               I_NRST,
  input logic               I_MAC_ENABLE_WR,
  input logic               I_MAC_ENABLE_VAL,
  input logic               I_TX_ENABLE_WR,
  input logic               I_TX_ENABLE_VAL,
  input logic               I_MCAST_RX_ENABLE_WR,
  input logic               I_MCAST_RX_ENABLE_VAL,
  input logic               I_STATION_ADDR_WR,
  input logic [47:0]        I_STATION_ADDR,
  input logic               I_MAC_INIT,
  input logic               I_HEARTBEAT_ERR,
  input logic               I_PHY_IS_100M,
  input logic               I_MII_PRESENT,
  input logic               I_ADMIN_WR,
  input logic [NUM_PHY-1:0] I_ADMIN_SEL,
  input logic               I_ADMIN_ENABLE,
  input logic               O_RX_ENABLE,
  input logic               O_TX_ENABLE,
  input logic               O_MCAST_RX_ENABLE,
  input logic [47:0]        O_STATION_ADDR,
  input logic               O_ABORT,
  input logic               O_PLS_RESET,
  input logic               O_MAC_BUSY,
  input logic [NUM_PHY-1:0] O_PHY_ADMIN,
  input logic [NUM_PHY-1:0] O_PHY_ISOLATE,
  input logic [CNT_W-1:0]   O_HEARTBEAT_ERR_COUNT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  // ----------------------------------------
  // Initialize sequence steps
  // ----------------------------------------
  sequence s_busy_run;
    O_MAC_BUSY[*8] ##1 O_MAC_BUSY[*8] ##1 O_MAC_BUSY[*4];
  endsequence
  sequence s_init_end;
    !O_MAC_BUSY && O_PLS_RESET;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mac_enable_set: assert property (I_MAC_ENABLE_WR && I_MAC_ENABLE_VAL |=>
    O_RX_ENABLE && O_TX_ENABLE && O_PLS_RESET) else $error("mac enable write not applied");
  a_mac_disable_clr: assert property (I_MAC_ENABLE_WR && !I_MAC_ENABLE_VAL |=>
    !O_RX_ENABLE && !O_TX_ENABLE && O_ABORT) else $error("mac disable write not applied");
  a_tx_enable_wr: assert property (I_TX_ENABLE_WR && !I_MAC_ENABLE_WR |=>
    O_TX_ENABLE == $past(I_TX_ENABLE_VAL)) else $error("transmit enable write not applied");
  a_mcast_enable_wr: assert property (I_MCAST_RX_ENABLE_WR |=>
    O_MCAST_RX_ENABLE == $past(I_MCAST_RX_ENABLE_VAL)) else $error("multicast enable wrong");
  a_station_addr_wr: assert property (I_STATION_ADDR_WR |=>
    O_STATION_ADDR == $past(I_STATION_ADDR)) else $error("station address not replaced");
  a_init_run: assert property (I_MAC_INIT && !O_MAC_BUSY |=>
    s_busy_run ##1 s_init_end) else $error("initialize sequence timing wrong");
  a_heartbeat_count: assert property (I_HEARTBEAT_ERR |=> O_HEARTBEAT_ERR_COUNT ==
    $past(O_HEARTBEAT_ERR_COUNT) + CNT_W'(!$past(I_PHY_IS_100M)))
    else $error("heartbeat error count wrong");
  a_admin_enable: assert property (I_ADMIN_WR && I_ADMIN_ENABLE |=>
    O_PHY_ADMIN == $past(I_ADMIN_SEL)) else $error("admin enable not exclusive");
  a_admin_disable: assert property (I_ADMIN_WR && !I_ADMIN_ENABLE |=>
    (O_PHY_ADMIN & $past(I_ADMIN_SEL)) == '0) else $error("admin disable not applied");
  a_isolate_follow: assert property ($past(I_NRST) |-> O_PHY_ISOLATE ==
    ($past(I_MII_PRESENT) ? ~$past(O_PHY_ADMIN) : '0)) else $error("isolate mismatch");
endmodule

bind mmcs_top mmcs_top_assertions #(.NUM_PHY(NUM_PHY), .CNT_W(CNT_W)) u_assert (.*);

// ==== testbench/mmcs_top_test.sv ====
// Self-checking testbench for the management control and statistics block
module mmcs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CLK_SYS, I_NRST, I_MAC_ENABLE_WR, I_MAC_ENABLE_VAL, I_TX_ENABLE_WR, I_TX_ENABLE_VAL;
  logic I_MCAST_RX_ENABLE_WR, I_MCAST_RX_ENABLE_VAL, I_STATION_ADDR_WR, I_MAC_INIT, I_GROUP_ADD;
  logic I_GROUP_DEL, I_SELF_TEST, I_MII_PRESENT, I_LOOPBACK_OK, I_SELF_TEST_FAIL, I_TX_DONE;
  logic I_TX_OK, I_CARRIER, I_SYMBOL_ERROR, I_COLLISION, I_HEARTBEAT_ERR, I_PHY_IS_100M;
  logic I_ADMIN_WR, I_ADMIN_ENABLE, I_ADMIN_NV_VALID;
  logic [47:0] I_STATION_ADDR, I_GROUP_ADDR, I_RX_DEST_ADDR, O_STATION_ADDR;
  logic [7:0]  I_PHY_KIND, O_PHY_KIND;
  logic [5:0]  I_TX_ATTEMPTS;
  logic [4:0]  I_HIST_INDEX;
  logic [1:0]  I_ADMIN_SEL, I_ADMIN_NV, O_PHY_ADMIN, O_PHY_ISOLATE;
  logic O_RX_ENABLE, O_TX_ENABLE, O_MCAST_RX_ENABLE, O_ADDR_ACCEPT, O_ABORT, O_PLS_RESET;
  logic O_MAC_BUSY, O_MII_LOOPBACK, O_SELF_TEST_DONE, O_SELF_TEST_PASS, O_FILTER_FULL;
  logic [31:0] O_HIST_COUNT, O_SYMBOL_ERR_COUNT, O_HEARTBEAT_ERR_COUNT;
  int          err_total;
  int          n_compared;
  int          hn[3] = '{1, 2, 32};
  logic [7:0]  kr[5] = '{8'h07, 8'h17, 8'h18, 8'hfe, 8'h63};
  logic [7:0]  ke[5] = '{8'h07, 8'h17, 8'h18, 8'hfe, 8'hff};
  localparam logic [47:0] STA = 48'h0a1b2c3d4e5e;
  localparam logic [47:0] GRP = 48'h01005e000011;

  mmcs_top u_dut (.*);

  initial begin
    I_CLK_SYS = 1'b0;
    forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge I_CLK_SYS);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick();
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic [47:0] a, input logic exp);
    I_RX_DEST_ADDR = a;
    tick(2);
    chk("accept", exp, O_ADDR_ACCEPT);
  endtask
  task automatic admin(input logic [1:0] sel, input logic en);
    I_ADMIN_SEL = sel;
    I_ADMIN_ENABLE = en;
    pulse(I_ADMIN_WR);
  endtask
  task automatic carrier(input logic err, input logic col);
    I_CARRIER = 1'b1;
    I_COLLISION = col;
    tick(2);
    I_SYMBOL_ERROR = err;
    tick();
    I_SYMBOL_ERROR = 1'b0;
    tick();
    I_SYMBOL_ERROR = err;
    tick();
    {I_CARRIER, I_COLLISION, I_SYMBOL_ERROR} = '0;
    tick(3);
  endtask
  task automatic self_test(input logic fail, input logic exp);
    int i;
    I_SELF_TEST_FAIL = fail;
    I_LOOPBACK_OK = 1'b0;
    pulse(I_SELF_TEST);
    for (i = 0; i < 500 && O_MII_LOOPBACK !== 1'b1; i++) tick();
    chk("loopback", 1, O_MII_LOOPBACK);
    if (i == 500) results();
    I_LOOPBACK_OK = 1'b1;
    for (i = 0; i < 500 && O_SELF_TEST_DONE !== 1'b1; i++) tick();
    chk("test_pass", exp, O_SELF_TEST_PASS);
    if (i == 500) results();
    tick(2);
    chk("loopback", 0, O_MII_LOOPBACK);
    {I_SELF_TEST_FAIL, I_LOOPBACK_OK} = '0;
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {I_NRST, I_MAC_ENABLE_WR, I_MAC_ENABLE_VAL, I_TX_ENABLE_WR, I_TX_ENABLE_VAL, I_MAC_INIT,
     I_MCAST_RX_ENABLE_WR, I_MCAST_RX_ENABLE_VAL, I_STATION_ADDR_WR, I_GROUP_ADD, I_GROUP_DEL,
     I_SELF_TEST, I_LOOPBACK_OK, I_SELF_TEST_FAIL, I_TX_DONE, I_TX_OK, I_CARRIER, I_COLLISION,
     I_SYMBOL_ERROR, I_HEARTBEAT_ERR, I_PHY_IS_100M, I_ADMIN_WR, I_ADMIN_ENABLE} = '0;
    {I_STATION_ADDR, I_GROUP_ADDR, I_RX_DEST_ADDR, I_PHY_KIND, I_TX_ATTEMPTS} = '0;
    {I_HIST_INDEX, I_ADMIN_SEL, I_ADMIN_NV, I_ADMIN_NV_VALID} = '0;
    I_MII_PRESENT = 1'b1;
    err_total = 0;
    n_compared = 0;
    tick(2);
    I_NRST = 1'b1;
    tick(2);
    chk("admin", 1, O_PHY_ADMIN);
    chk("isolate", 2, O_PHY_ISOLATE);
    I_MAC_ENABLE_VAL = 1'b1;
    {I_MAC_ENABLE_WR, I_TX_ENABLE_WR} = 2'b11;
    tick();
    {I_MAC_ENABLE_WR, I_TX_ENABLE_WR} = 2'b00;
    chk("rx_en", 1, O_RX_ENABLE);
    chk("tx_en", 1, O_TX_ENABLE);
    chk("pls_reset", 1, O_PLS_RESET);
    pulse(I_TX_ENABLE_WR);
    chk("tx_en", 0, O_TX_ENABLE);
    I_TX_ENABLE_VAL = 1'b1;
    pulse(I_TX_ENABLE_WR);
    chk("tx_en", 1, O_TX_ENABLE);
    I_STATION_ADDR = STA;
    pulse(I_STATION_ADDR_WR);
    chk("station", STA, O_STATION_ADDR);
    acc(STA, 1);
    acc(48'h0a1b2c3d4e60, 0);
    acc(GRP, 0);
    I_GROUP_ADDR = GRP;
    pulse(I_GROUP_ADD);
    acc(GRP, 1);
    pulse(I_MCAST_RX_ENABLE_WR);
    chk("mcast", 0, O_MCAST_RX_ENABLE);
    acc(GRP, 0);
    I_MCAST_RX_ENABLE_VAL = 1'b1;
    pulse(I_MCAST_RX_ENABLE_WR);
    acc(GRP, 1);
    acc(48'hffffffffffff, 1);
    pulse(I_GROUP_DEL);
    acc(GRP, 0);
    admin(2'b01, 1'b0);
    chk("admin", 0, O_PHY_ADMIN);
    acc(STA, 0);
    admin(2'b10, 1'b1);
    chk("admin", 2, O_PHY_ADMIN);
    tick();
    chk("isolate", 1, O_PHY_ISOLATE);
    I_MII_PRESENT = 1'b0;
    tick();
    chk("isolate", 0, O_PHY_ISOLATE);
    I_MII_PRESENT = 1'b1;
    acc(STA, 1);
    I_TX_OK = 1'b1;
    foreach (hn[k]) begin
      I_HIST_INDEX = 5'(hn[k] - 1);
      I_TX_ATTEMPTS = 6'(hn[k]);
      pulse(I_TX_DONE);
      chk("hist", 1, O_HIST_COUNT);
    end
    I_TX_OK = 1'b0;
    pulse(I_TX_DONE);
    chk("hist", 1, O_HIST_COUNT);
    carrier(1'b1, 1'b0);
    chk("symbol_err", 1, O_SYMBOL_ERR_COUNT);
    carrier(1'b1, 1'b1);
    carrier(1'b0, 1'b0);
    chk("symbol_err", 1, O_SYMBOL_ERR_COUNT);
    pulse(I_HEARTBEAT_ERR);
    I_PHY_IS_100M = 1'b1;
    pulse(I_HEARTBEAT_ERR);
    chk("heartbeat", 1, O_HEARTBEAT_ERR_COUNT);
    foreach (kr[k]) begin
      I_PHY_KIND = kr[k];
      tick(2);
      chk("phy_kind", ke[k], O_PHY_KIND);
    end
    for (int j = 0; j < 16; j++) begin
      I_GROUP_ADDR = GRP + 48'(2 * j);
      pulse(I_GROUP_ADD);
    end
    tick(2);
    chk("full", 1, O_FILTER_FULL);
    pulse(I_MAC_INIT);
    chk("busy", 1, O_MAC_BUSY);
    tick(20);
    chk("busy", 0, O_MAC_BUSY);
    chk("pls_reset", 1, O_PLS_RESET);
    chk("full", 0, O_FILTER_FULL);
    self_test(1'b0, 1'b1);
    self_test(1'b1, 1'b0);
    I_MAC_ENABLE_VAL = 1'b0;
    pulse(I_MAC_ENABLE_WR);
    chk("rx_en", 0, O_RX_ENABLE);
    chk("tx_en", 0, O_TX_ENABLE);
    chk("abort", 1, O_ABORT);
    acc(STA, 0);
    {I_ADMIN_NV, I_ADMIN_NV_VALID, I_NRST} = 4'b1010;
    tick(2);
    I_NRST = 1'b1;
    tick(2);
    chk("admin", 2, O_PHY_ADMIN);
    results();
  end
endmodule
